// [hdl/chc_device.sv]
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - enable pin edges set, clear converter bit
// - host raises enable only when disabled
// - any fault clears converter enable
// - enable edge during fault raises blocked event
// - re-enable needs fault status, fault event cleared
// - level irq, selectable drive and polarity
// - irq while any unmasked event pending
// - events during event read held back
// - pure slave, no stretching or delay
// - idle scl beyond 35 ms resets interface
// - nine pulses release stuck data line
// - master code selects high speed once
// - continuous high speed configuration bit
// - address zero selects page, lsb ignored
// - four slave addresses select pages
// - bytes of eight bits, msb first
// - acknowledge own address and write bytes
// - host reads via address write, restart
// - acked reads auto-increment, unmapped reads zero
// - host repeats slave address after restart
// - consecutive writes store, ack, increment
// - repeated write uses address data pairs
// - start or stop mid message aborts
module chc_device #(
	parameter int         TIMEOUT_CYC = chc_pkg::TIMEOUT_CYC,
	parameter logic [6:0] BASE_ADDR   = chc_pkg::BASE_RST
) (
	input  wire logic clk_sys,
	input  wire logic rstn,
	chc_link_if.dev   link,
	input  wire logic input_sag_fault,
	input  wire logic input_overvoltage_fault,
	input  wire logic input_undervoltage_fault,
	input  wire logic battery_overvoltage_fault,
	input  wire logic battery_undervoltage_fault,
	input  wire logic interface_supply_low_fault,
	input  wire logic critical_temperature_fault,
	output logic      converter_enable,
	output logic      high_speed_active
);
	if (TIMEOUT_CYC < 16) $error("TIMEOUT_CYC too small");

	localparam int TW = $clog2(TIMEOUT_CYC + 1);

	typedef enum {ST_IDLE, ST_RX, ST_RXACK, ST_TX, ST_TXACK} chc_dst_e;
	typedef enum {K_ADDR, K_REG, K_DATA} chc_kind_e;

	logic [9:0]    s1_q;
	logic [9:0]    s2_q;
	logic [2:0]    p_q;
	logic [6:0]    pf_q;
	chc_dst_e      st_q;
	chc_kind_e     kind_q;
	logic [3:0]    cnt_q;
	logic [7:0]    sh_q;
	logic [7:0]    txsh_q;
	logic [7:0]    ptr_q;
	logic [7:0]    page_q;
	logic          ack_q;
	logic          rd_q;
	logic          mack_q;
	logic          hs_q;
	logic          oe_q;
	logic [TW-1:0] idle_q;
	logic [3:0]    clr_q;
	logic [7:0]    ctrl_q;
	logic [7:0]    mask_q;
	logic [6:0]    base_q;
	logic [1:0]    evt_q;
	logic [1:0]    hold_q;
	logic          conv_q;
	logic          irq_o_q;
	logic          irq_oe_q;
	logic          hs_out_q;
	logic          scl;
	logic          sda;
	logic          scl_r;
	logic          scl_f;
	logic          start;
	logic          stop;
	logic          tmo;
	logic          bus_clr;
	logic          en_r;
	logic          en_f;
	logic [6:0]    flt;
	logic          flt_any;
	logic          blocked;
	logic [1:0]    new_ev;
	logic          rd_evt;
	logic          wr_stb;
	logic          addr_hit;
	logic [7:0]    rd_val;

	////////////////////////////////////////////////////////////////////////
	// input synchronisers; edges only from the second stage on
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			s1_q <= 10'h003;
			s2_q <= 10'h003;
			p_q  <= 3'h3;
			pf_q <= 7'h00;
		end
		else
		begin
			s1_q <= {critical_temperature_fault, interface_supply_low_fault,
				battery_undervoltage_fault, battery_overvoltage_fault,
				input_undervoltage_fault, input_overvoltage_fault,
				input_sag_fault, link.en, link.sda, link.scl};
			s2_q <= s1_q;
			p_q  <= s2_q[2:0];
			pf_q <= s2_q[9:3];
		end

	assign scl     = s2_q[0];
	assign sda     = s2_q[1];
	assign flt     = s2_q[9:3];
	assign scl_r   = scl & ~p_q[0];
	assign scl_f   = ~scl & p_q[0];
	assign start   = scl & p_q[0] & ~sda & p_q[1];
	assign stop    = scl & p_q[0] & sda & ~p_q[1];
	assign en_r    = s2_q[2] & ~p_q[2];
	assign en_f    = ~s2_q[2] & p_q[2];
	assign flt_any = |flt;
	assign blocked = flt_any | evt_q[chc_pkg::EVT_FAULT];
	assign new_ev  = {en_r & blocked, |(flt & ~pf_q)};
	assign tmo     = idle_q == TW'(TIMEOUT_CYC);
	assign bus_clr = clr_q == chc_pkg::BUS_CLR_PULSES;
	assign wr_stb  = st_q == ST_RX && scl_f && cnt_q == 4'h8 && kind_q == K_DATA;
	assign rd_evt  = (st_q == ST_TX || st_q == ST_TXACK) && page_q == 8'h00
		&& ptr_q == chc_pkg::REG_EVT;
	assign addr_hit = ctrl_q[chc_pkg::C_MULTI] ? sh_q[7:3] == base_q[6:2]
		: sh_q[7:1] == base_q;

	// pages other than zero hold only the page register
	always_comb
	begin
		rd_val = 8'h00;
		if (ptr_q == chc_pkg::REG_PAGE)
			rd_val = page_q;
		else if (page_q == 8'h00)
			case (ptr_q)
				chc_pkg::REG_EVT:  rd_val = {6'h00, evt_q};
				chc_pkg::REG_STAT: rd_val = {5'h00, ~conv_q, flt_any, s2_q[2]};
				chc_pkg::REG_MASK: rd_val = mask_q;
				chc_pkg::REG_CTRL: rd_val = {ctrl_q[7:1], conv_q};
				chc_pkg::REG_BASE: rd_val = {1'h0, base_q};
				default:           rd_val = 8'h00;
			endcase
	end

	////////////////////////////////////////////////////////////////////////
	// serial slave; scl is never driven, so the master sets the pace
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			st_q   <= ST_IDLE;
			kind_q <= K_ADDR;
			cnt_q  <= 4'h0;
			sh_q   <= 8'h00;
			txsh_q <= 8'h00;
			ptr_q  <= 8'h00;
			page_q <= 8'h00;
			ack_q  <= 1'h0;
			rd_q   <= 1'h0;
			mack_q <= 1'h0;
			hs_q   <= 1'h0;
			oe_q   <= 1'h0;
		end
		else if (start)
		begin
			st_q   <= ST_RX;
			kind_q <= K_ADDR;
			cnt_q  <= 4'h0;
			oe_q   <= 1'h0;
		end
		else if (stop || tmo || bus_clr)
		begin
			st_q <= ST_IDLE;
			oe_q <= 1'h0;
			if (stop)
				hs_q <= 1'h0;
			if (stop && ctrl_q[chc_pkg::C_PAGE_AUTO_RETURN])
				page_q <= 8'h00;
		end
		else
			case (st_q)
				ST_RX:
					if (scl_r && cnt_q < 4'h8)
					begin
						sh_q  <= {sh_q[6:0], sda};
						cnt_q <= cnt_q + 4'h1;
					end
					else if (scl_f && cnt_q == 4'h8)
					begin
						cnt_q <= 4'h0;
						st_q  <= ST_RXACK;
						ack_q <= 1'h1;
						oe_q  <= 1'h1;
						rd_q  <= 1'h0;
						case (kind_q)
							K_ADDR:
								if (sh_q[7:3] == chc_pkg::HS_CODE)
								begin
									hs_q  <= 1'h1;
									ack_q <= 1'h0;
									oe_q  <= 1'h0;
								end
								else if (addr_hit)
								begin
									rd_q   <= sh_q[0];
									kind_q <= K_REG;
									if (ctrl_q[chc_pkg::C_MULTI])
										page_q <= {5'h00, sh_q[2:1], 1'h0};
								end
								else
								begin
									ack_q <= 1'h0;
									oe_q  <= 1'h0;
								end
							K_REG:
							begin
								ptr_q  <= sh_q;
								kind_q <= K_DATA;
							end
							default:
							begin
								if (ptr_q == chc_pkg::REG_PAGE)
									page_q <= sh_q & chc_pkg::PAGE_MASK;
								if (ctrl_q[chc_pkg::C_RPTW])
									kind_q <= K_REG;
								else
									ptr_q <= ptr_q + 8'h01;
							end
						endcase
					end
				ST_RXACK:
					if (scl_f)
					begin
						oe_q <= 1'h0;
						if (!ack_q)
							st_q <= ST_IDLE;
						else if (rd_q)
						begin
							st_q   <= ST_TX;
							oe_q   <= ~rd_val[7];
							txsh_q <= {rd_val[6:0], 1'h0};
							cnt_q  <= 4'h1;
						end
						else
							st_q <= ST_RX;
					end
				ST_TX:
					if (scl_f && cnt_q == 4'h8)
					begin
						oe_q <= 1'h0;
						st_q <= ST_TXACK;
					end
					else if (scl_f)
					begin
						oe_q   <= ~txsh_q[7];
						txsh_q <= {txsh_q[6:0], 1'h0};
						cnt_q  <= cnt_q + 4'h1;
					end
				ST_TXACK:
					if (scl_r)
					begin
						mack_q <= ~sda;
						if (!sda)
							ptr_q <= ptr_q + 8'h01;
					end
					else if (scl_f && mack_q)
					begin
						st_q   <= ST_TX;
						oe_q   <= ~rd_val[7];
						txsh_q <= {rd_val[6:0], 1'h0};
						cnt_q  <= 4'h1;
					end
					else if (scl_f)
						st_q <= ST_IDLE;
				default:
					st_q <= ST_IDLE;
			endcase

	// the timeout only runs mid-message, so a parked bus never trips it
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			idle_q <= '0;
		else if (!ctrl_q[chc_pkg::C_TO] || st_q == ST_IDLE || scl_r || scl_f || tmo)
			idle_q <= '0;
		else
			idle_q <= idle_q + 1'h1;

	// more than eight rising edges with our own drive held means stuck
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			clr_q <= 4'h0;
		else if (!oe_q || st_q == ST_RXACK || bus_clr)
			clr_q <= 4'h0;
		else if (scl_r)
			clr_q <= clr_q + 4'h1;

	////////////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			ctrl_q <= chc_pkg::CTRL_RST;
			mask_q <= chc_pkg::MASK_RST;
			base_q <= BASE_ADDR;
		end
		else if (wr_stb && page_q == 8'h00)
			case (ptr_q)
				chc_pkg::REG_MASK: mask_q <= sh_q;
				chc_pkg::REG_CTRL: ctrl_q <= sh_q;
				chc_pkg::REG_BASE: base_q <= sh_q[6:0];
				default: ;
			endcase

	// faults win over every enable source
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			conv_q <= 1'h0;
		else if (flt_any)
			conv_q <= 1'h0;
		else if (en_f)
			conv_q <= 1'h0;
		else if (en_r)
			conv_q <= ~blocked;
		else if (wr_stb && page_q == 8'h00 && ptr_q == chc_pkg::REG_CTRL)
			conv_q <= sh_q[chc_pkg::C_CONV] & ~blocked;

	// new events wait while the event register is on the wire
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			evt_q  <= 2'h0;
			hold_q <= 2'h0;
		end
		else if (rd_evt)
			hold_q <= hold_q | new_ev;
		else
		begin
			hold_q <= 2'h0;
			if (wr_stb && page_q == 8'h00 && ptr_q == chc_pkg::REG_EVT)
				evt_q <= (evt_q & ~sh_q[1:0]) | new_ev | hold_q;
			else
				evt_q <= evt_q | new_ev | hold_q;
		end

	// push-pull drives both levels; open drain only pulls active
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			irq_o_q  <= 1'h1;
			irq_oe_q <= 1'h0;
			hs_out_q <= 1'h0;
		end
		else
		begin
			if (ctrl_q[chc_pkg::C_OD])
			begin
				irq_o_q  <= 1'h0;
				irq_oe_q <= |(evt_q & ~mask_q[1:0]);
			end
			else
			begin
				irq_o_q  <= (|(evt_q & ~mask_q[1:0])) ~^ ctrl_q[chc_pkg::C_POL];
				irq_oe_q <= 1'h1;
			end
			hs_out_q <= hs_q | ctrl_q[chc_pkg::C_HS];
		end

	assign link.sda_d_o   = 1'h0;
	assign link.sda_d_oe  = oe_q;
	assign link.irq_o     = irq_o_q;
	assign link.irq_oe    = irq_oe_q;
	assign converter_enable  = conv_q;
	assign high_speed_active = hs_out_q;
endmodule // chc_device
`default_nettype wire

// [hdl/chc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module chc_host #(
	parameter int QTR = chc_pkg::H_QTR_RST
) (
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	chc_link_if.host         link
);
	if (QTR < 3) $error("QTR below 3 outruns the device input sampling");

	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} chc_hst_e;

	chc_hst_e   st_q;
	logic [4:0] cmd_q;
	logic [7:0] txd_q;
	logic [7:0] txsh_q;
	logic [7:0] rxd_q;
	logic       nack_q;
	logic       en_q;
	logic       own_q;
	logic [1:0] q_q;
	logic [3:0] bitn_q;
	logic [7:0] qcnt_q;
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic       scl_oe_q;
	logic       sda_oe_q;
	logic       acc;
	logic       fire;
	logic       tick;
	logic       done;

	function automatic chc_hst_e nxt(input logic [4:0] c);
		if (c[chc_pkg::CMD_START])
			return H_START;
		if (c[chc_pkg::CMD_WR] | c[chc_pkg::CMD_RD])
			return H_BIT;
		if (c[chc_pkg::CMD_STOP])
			return H_STOP;
		return H_IDLE;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb slave: one wait state, writes land at the pready edge
	assign acc  = psel & penable & ~pready;
	assign fire = psel & penable & pready & pwrite;

	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			pready  <= 1'h0;
			pslverr <= 1'h0;
			prdata  <= 32'h0;
		end
		else
		begin
			pready  <= acc;
			pslverr <= acc & ~(paddr inside {chc_pkg::H_CMD, chc_pkg::H_TXD,
				chc_pkg::H_STAT, chc_pkg::H_PIN});
			if (acc)
				case (paddr)
					chc_pkg::H_TXD:  prdata <= {24'h0, txd_q};
					chc_pkg::H_STAT: prdata <= {20'h0, s2_q[2], en_q, nack_q,
						st_q != H_IDLE, rxd_q};
					chc_pkg::H_PIN:  prdata <= {31'h0, en_q};
					default:         prdata <= 32'h0;
				endcase
		end

	// software raises the pin only after reading the device disabled
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			txd_q <= 8'h00;
			en_q  <= 1'h0;
		end
		else if (fire)
		begin
			if (paddr == chc_pkg::H_TXD)
				txd_q <= pwdata[7:0];
			if (paddr == chc_pkg::H_PIN)
				en_q <= pwdata[0];
		end

	////////////////////////////////////////////////////////////////////////
	// link inputs: two stages before use
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			s1_q <= 3'h7;
			s2_q <= 3'h7;
		end
		else
		begin
			s1_q <= {link.irq, link.sda, link.scl};
			s2_q <= s1_q;
		end

	assign tick = (st_q != H_IDLE) && (qcnt_q == 8'(QTR - 1));
	assign done = tick && (q_q == 2'h3);

	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			qcnt_q <= 8'h00;
		else if (st_q == H_IDLE || tick)
			qcnt_q <= 8'h00;
		else
			qcnt_q <= qcnt_q + 8'h01;

	////////////////////////////////////////////////////////////////////////
	// byte engine; commands while busy are dropped
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			st_q   <= H_IDLE;
			cmd_q  <= 5'h00;
			txsh_q <= 8'h00;
			rxd_q  <= 8'h00;
			nack_q <= 1'h0;
			own_q  <= 1'h0;
			q_q    <= 2'h0;
			bitn_q <= 4'h0;
		end
		else
			case (st_q)
				H_IDLE:
					if (fire && paddr == chc_pkg::H_CMD)
					begin
						cmd_q  <= pwdata[4:0];
						st_q   <= nxt(pwdata[4:0]);
						txsh_q <= txd_q;
						q_q    <= 2'h0;
						bitn_q <= 4'h0;
					end
				H_START:
					if (done)
					begin
						own_q <= 1'h1;
						cmd_q <= cmd_q & 5'h1E;
						st_q  <= nxt(cmd_q & 5'h1E);
						q_q   <= 2'h0;
					end
					else if (tick)
						q_q <= q_q + 2'h1;
				H_BIT:
					if (tick)
					begin
						q_q <= q_q + 2'h1;
						if (q_q == 2'h2 && bitn_q < 4'h8)
							rxd_q <= {rxd_q[6:0], s2_q[1]};
						if (q_q == 2'h2 && bitn_q == 4'h8)
							nack_q <= s2_q[1];
						if (q_q == 2'h3)
						begin
							txsh_q <= {txsh_q[6:0], 1'h0};
							bitn_q <= bitn_q + 4'h1;
						end
						if (done && bitn_q == 4'h8)
						begin
							cmd_q  <= cmd_q & 5'h11;
							st_q   <= nxt(cmd_q & 5'h11);
							bitn_q <= 4'h0;
						end
					end
				H_STOP:
					if (done)
					begin
						own_q <= 1'h0;
						cmd_q <= 5'h00;
						st_q  <= H_IDLE;
					end
					else if (tick)
						q_q <= q_q + 2'h1;
				default:
					st_q <= H_IDLE;
			endcase

	// pin drive from phase and quarter; in data bits sda only moves while scl is low, start and stop move it with scl high
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
		begin
			scl_oe_q <= 1'h0;
			sda_oe_q <= 1'h0;
		end
		else
			case (st_q)
				H_START:
				begin
					scl_oe_q <= q_q == 2'h0 || q_q == 2'h3;
					sda_oe_q <= q_q[1];
				end
				H_BIT:
				begin
					scl_oe_q <= q_q == 2'h0 || q_q == 2'h3;
					if (cmd_q[chc_pkg::CMD_RD])
						sda_oe_q <= bitn_q == 4'h8 && !cmd_q[chc_pkg::CMD_NACK];
					else
						sda_oe_q <= bitn_q < 4'h8 && !txsh_q[7];
				end
				H_STOP:
				begin
					scl_oe_q <= q_q == 2'h0;
					sda_oe_q <= !q_q[1];
				end
				default:
				begin
					scl_oe_q <= own_q;
					sda_oe_q <= 1'h0;
				end
			endcase

	assign link.scl_h_o  = 1'h0;
	assign link.sda_h_o  = 1'h0;
	assign link.scl_h_oe = scl_oe_q;
	assign link.sda_h_oe = sda_oe_q;
	assign link.en       = en_q;
endmodule // chc_host
`default_nettype wire

// [hdl/chc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface chc_link_if;
	logic scl_h_o;
	logic scl_h_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic irq_o;
	logic irq_oe;
	logic en;
	wire  scl;
	wire  sda;
	wire  irq;
	// pull-ups: a line is low only while an enabled driver drives low
	assign scl = ~(scl_h_oe & ~scl_h_o);
	assign sda = ~(sda_h_oe & ~sda_h_o) & ~(sda_d_oe & ~sda_d_o);
	assign irq = irq_oe ? irq_o : 1'h1;
	modport dev (input scl, sda, en, output sda_d_o, sda_d_oe, irq_o, irq_oe);
	modport host (input scl, sda, irq, output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, en);
endinterface // chc_link_if
`default_nettype wire

// [hdl/chc_pkg.sv]
package chc_pkg;
	// device register map, page 0
	localparam logic [7:0] REG_PAGE  = 8'h00;
	localparam logic [7:0] REG_EVT   = 8'h01;
	localparam logic [7:0] REG_STAT  = 8'h02;
	localparam logic [7:0] REG_MASK  = 8'h03;
	localparam logic [7:0] REG_CTRL  = 8'h04;
	localparam logic [7:0] REG_BASE  = 8'h05;
	localparam logic [7:0] PAGE_MASK = 8'hFE;
	// event bits
	localparam int EVT_FAULT = 0;
	localparam int EVT_BLOCK = 1;
	// control bits
	localparam int C_CONV   = 0;
	localparam int C_PAGE_AUTO_RETURN = 1;
	localparam int C_TO     = 2;
	localparam int C_HS     = 3;
	localparam int C_MULTI  = 4;
	localparam int C_RPTW   = 5;
	localparam int C_OD     = 6;
	localparam int C_POL    = 7;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [6:0] BASE_RST = 7'h2A;
	localparam logic [4:0] HS_CODE  = 5'h01;
	localparam logic [3:0] BUS_CLR_PULSES = 4'h9;
	// idle timeout
	localparam int TIMEOUT_MS  = 35;
	localparam int CLK_HZ      = 20000000;
	localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
	// host APB map
	localparam logic [7:0] H_CMD  = 8'h00;
	localparam logic [7:0] H_TXD  = 8'h04;
	localparam logic [7:0] H_STAT = 8'h08;
	localparam logic [7:0] H_PIN  = 8'h0C;
	localparam int CMD_START = 0;
	localparam int CMD_WR    = 1;
	localparam int CMD_RD    = 2;
	localparam int CMD_NACK  = 3;
	localparam int CMD_STOP  = 4;
	localparam int H_QTR_RST = 5;
endpackage

// [verification/chc_props.sv]
`timescale 1ns/1ps
`default_nettype none
module chc_props (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_d_oe,
	input wire logic irq_o,
	input wire logic irq_oe
);
	logic [4:0] hi_q;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////////////
	// long idle high clock: no device drive may survive it
	always_ff @(posedge clk_sys or negedge rstn)
		if (!rstn)
			hi_q <= 5'h00;
		else if (!scl)
			hi_q <= 5'h00;
		else if (hi_q != 5'h1F)
			hi_q <= hi_q + 5'h01;
	////////////////////////////////////////////////////////////////////////////////
	a_irq_idle_high: assert property ($rose(rstn) |-> irq_o)
		else $error("irq not idle after reset");
	a_irq_push_pull: assert property ($rose(rstn) |-> ##[0:2] irq_oe)
		else $error("irq not driven after reset");
	a_drive_low_phase: assert property ($rose(sda_d_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
		else $error("device drive started outside clock low");
	a_drive_stands: assert property ($rose(sda_d_oe) |-> sda_d_oe [*8])
		else $error("device drive too short");
	a_bit_stable_high: assert property ($rose(scl) |-> $stable(sda_d_oe) [*2])
		else $error("device data moved while clock high");
	a_start_not_dev: assert property (scl && $past(scl) && $fell(sda) |-> !$past(sda_d_oe))
		else $error("device made a start");
	a_stop_idle: assert property (scl && $past(scl) && $rose(sda) |-> !sda_d_oe [*4])
		else $error("device drives after stop");
	a_idle_released: assert property (hi_q == 5'h1F |-> !sda_d_oe)
		else $error("device drives on idle bus");
	c_dev_drive: cover property ($rose(sda_d_oe));
	c_start: cover property (scl && $fell(sda));
	c_irq: cover property ($fell(irq_o));
endmodule // chc_props
`default_nettype wire

// [verification/tb_charger_host_control_port.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_charger_host_control_port;
	localparam logic [7:0] SW = {chc_pkg::BASE_RST, 1'h0};
	localparam logic [4:0] RD_END = 5'h1C;
	logic        clk_sys = 1'h0;
	logic        rstn    = 1'h0;
	logic [7:0]  paddr   = 8'h00;
	logic        psel    = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite  = 1'h0;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  flt     = 7'h00;
	logic        cen;
	logic        hsa;
	logic [7:0]  exp_q[$];
	logic [7:0]  obs_q[$];
	logic [7:0]  m;
	logic [31:0] s;
	logic        perr;
	int          fails = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          i;
	always #25 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////////////////////
	chc_link_if u_chc_link_if ();
	chc_host #(.QTR(chc_pkg::H_QTR_RST)) u_chc_host (.clk_sys(clk_sys), .rstn(rstn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(u_chc_link_if));
	// short timeout keeps the idle-reset path reachable in a short run
	chc_device #(.TIMEOUT_CYC(200), .BASE_ADDR(chc_pkg::BASE_RST)) u_chc_device (
		.clk_sys(clk_sys), .rstn(rstn), .link(u_chc_link_if),
		.input_sag_fault(flt[0]), .input_overvoltage_fault(flt[1]),
		.input_undervoltage_fault(flt[2]), .battery_overvoltage_fault(flt[3]),
		.battery_undervoltage_fault(flt[4]), .interface_supply_low_fault(flt[5]),
		.critical_temperature_fault(flt[6]), .converter_enable(cen), .high_speed_active(hsa));
	chc_props u_chc_props (.clk_sys(clk_sys), .rstn(rstn), .scl(u_chc_link_if.scl),
		.sda(u_chc_link_if.sda), .sda_d_oe(u_chc_link_if.sda_d_oe),
		.irq_o(u_chc_link_if.irq_o), .irq_oe(u_chc_link_if.irq_oe));
	////////////////////////////////////////////////////////////////////////////////
	task test_done();
		if (fails == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task note(input logic [7:0] seen, input logic [7:0] exp);
		obs_q.push_back(seen);
		exp_q.push_back(exp);
	endtask
	always @(posedge clk_sys)
		while (obs_q.size() > 0)
			check(obs_q.pop_front(), exp_q.pop_front());
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 80000)
		begin
			fails++;
			test_done();
		end
	end
	// entered right after a rising edge; returns one edge after the answer
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'h1;
		do @(posedge clk_sys); while (pready !== 1'h1);
		r = prdata;
		perr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk_sys);
	endtask
	task cmd(input logic [4:0] c, input logic [7:0] d, output logic [31:0] st);
		apb(1'h1, chc_pkg::H_TXD, {24'h0, d}, st);
		apb(1'h1, chc_pkg::H_CMD, {27'h0, c}, st);
		do apb(1'h0, chc_pkg::H_STAT, 32'h0, st); while (st[8] !== 1'h0);
	endtask
	task wbytes(input logic [7:0] b[$]);
		int k;
		for (k = 0; k < b.size(); k++)
			cmd((k == 0) ? 5'h03 : ((k == b.size() - 1) ? 5'h12 : 5'h02), b[k], s);
	endtask
	task rregs(input logic [7:0] sw, input logic [7:0] r, input logic [7:0] e[$]);
		int k;
		cmd(5'h03, sw, s);
		cmd(5'h02, r, s);
		cmd(5'h03, sw | 8'h01, s);
		for (k = 0; k < e.size(); k++)
		begin
			cmd((k == e.size() - 1) ? RD_END : 5'h04, 8'h00, s);
			note(s[7:0], e[k]);
		end
	endtask
	task pin(input logic v);
		apb(1'h1, chc_pkg::H_PIN, {31'h0, v}, s);
		repeat (10) @(posedge clk_sys);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(77953));
		repeat (2) @(posedge clk_sys);
		rstn <= 1'h1;
		repeat (4) @(posedge clk_sys);
		// event bits stay unmasked so the irq line can be judged
		m = 8'($urandom()) & 8'hFC;
		wbytes('{SW, chc_pkg::REG_MASK, m, chc_pkg::CTRL_RST});
		rregs(SW, chc_pkg::REG_MASK, '{m, chc_pkg::CTRL_RST, {1'h0, chc_pkg::BASE_RST}, 8'h00});
		cmd(5'h03, SW ^ 8'h02, s);
		note({7'h0, s[9]}, 8'h01);
		cmd(5'h10, 8'h00, s);
		wbytes('{SW, chc_pkg::REG_PAGE, 8'h03});
		rregs(SW, chc_pkg::REG_PAGE, '{8'h02, 8'h00, 8'h00, 8'h00});
		// run from page through event, status and mask up to ctrl; mask keeps its value
		wbytes('{SW, chc_pkg::REG_PAGE, 8'h00, 8'h00, 8'h00, m, 8'h10});
		for (i = 0; i < 4; i++)
			rregs({chc_pkg::BASE_RST[6:2], i[1:0], 1'h0}, chc_pkg::REG_PAGE, '{8'(2 * i)});
		wbytes('{{chc_pkg::BASE_RST[6:2], 3'h0}, chc_pkg::REG_CTRL, 8'h00});
		cmd(5'h03, 8'h08, s);
		note({7'h0, s[9]}, 8'h01);
		note({7'h0, hsa}, 8'h01);
		rregs(SW, chc_pkg::REG_BASE, '{{1'h0, chc_pkg::BASE_RST}});
		note({7'h0, hsa}, 8'h00);
		wbytes('{SW, chc_pkg::REG_CTRL, 8'h08});
		note({7'h0, hsa}, 8'h01);
		wbytes('{SW, chc_pkg::REG_CTRL, 8'h20});
		m = 8'($urandom()) & 8'hFC;
		// pairs would land in ctrl and base if taken as a run
		wbytes('{SW, chc_pkg::REG_MASK, m, chc_pkg::REG_CTRL, 8'h00});
		rregs(SW, chc_pkg::REG_MASK, '{m, 8'h00, {1'h0, chc_pkg::BASE_RST}});
		note({7'h0, hsa}, 8'h00);
		for (i = 0; i < 7; i++)
		begin
			pin(1'h1);
			note({7'h0, cen}, 8'h01);
			flt <= 7'h01 << i;
			repeat (10) @(posedge clk_sys);
			note({7'h0, cen}, 8'h00);
			pin(1'h0);
			pin(1'h1);
			note({7'h0, cen}, 8'h00);
			flt <= 7'h00;
			pin(1'h0);
			pin(1'h1);
			note({7'h0, cen}, 8'h00);
			rregs(SW, chc_pkg::REG_EVT, '{8'h03});
			apb(1'h0, chc_pkg::H_STAT, 32'h0, s);
			note({7'h0, s[11]}, 8'h00);
			wbytes('{SW, chc_pkg::REG_EVT, 8'h03});
			apb(1'h0, chc_pkg::H_STAT, 32'h0, s);
			note({7'h0, s[11]}, 8'h01);
			pin(1'h0);
			note({7'h0, cen}, 8'h00);
			pin(1'h1);
			note({7'h0, cen}, 8'h01);
			pin(1'h0);
		end
		// a stalled message is dropped, so the next byte finds no listener
		wbytes('{SW, chc_pkg::REG_CTRL, 8'h04});
		cmd(5'h03, SW, s);
		repeat (250) @(posedge clk_sys);
		cmd(5'h12, chc_pkg::REG_MASK, s);
		note({7'h0, s[9]}, 8'h01);
		// active-high push-pull rests low, open drain rests released
		wbytes('{SW, chc_pkg::REG_CTRL, 8'h80});
		apb(1'h0, chc_pkg::H_STAT, 32'h0, s);
		note({7'h0, s[11]}, 8'h00);
		wbytes('{SW, chc_pkg::REG_CTRL, 8'h40});
		apb(1'h0, chc_pkg::H_STAT, 32'h0, s);
		note({7'h0, s[11]}, 8'h01);
		cmd(5'h03, SW, s);
		cmd(5'h02, chc_pkg::REG_EVT, s);
		cmd(5'h03, SW | 8'h01, s);
		// a fault lands while the event byte is on the wire
		fork
			cmd(RD_END, 8'h00, s);
			begin
				repeat (60) @(posedge clk_sys);
				flt <= 7'h01;
			end
		join
		note(s[7:0], 8'h00);
		flt <= 7'h00;
		rregs(SW, chc_pkg::REG_EVT, '{8'h01});
		apb(1'h0, chc_pkg::H_STAT, 32'h0, s);
		note({7'h0, s[11]}, 8'h00);
		note({7'h0, perr}, 8'h00);
		apb(1'h0, 8'h10, 32'h0, s);
		note({7'h0, perr}, 8'h01);
		repeat (2) @(posedge clk_sys);
		test_done();
	end
endmodule // tb_charger_host_control_port
`default_nettype wire
